// File: src/dsq_map.svh
// constants of the dma transfer mode sequencer: offsets, fields, encodings
`ifndef DSQ_MAP_SVH
`define DSQ_MAP_SVH

// channel count and control table geometry
`define DSQ_NCH        32
`define DSQ_CH_W       5
`define DSQ_ALT_OFF    32'h0000_0200
`define DSQ_BASE_LSB   10
`define DSQ_STRIDE_SH  4

// word index inside one control structure
`define DSQ_W_SRC      2'h0
`define DSQ_W_DST      2'h1
`define DSQ_W_CW       2'h2
`define DSQ_W_LAST     2'h3

// control word fields
`define DSQ_MODE_LSB   0
`define DSQ_MODE_W     3
`define DSQ_CNT_LSB    4
`define DSQ_CNT_W      10

// mode encodings, all distinct
`define DSQ_M_STOP     3'h0
`define DSQ_M_BASIC    3'h1
`define DSQ_M_AUTO     3'h2
`define DSQ_M_PP       3'h3
`define DSQ_M_MSG      3'h4
`define DSQ_M_PSG      3'h6

// reset values
`define DSQ_RST_ALT    32'h0000_0000

`endif

// File: src/dsq_pkg.sv
// types shared by the dma transfer mode sequencer modules
package dsq_pkg;

  // sequencer states, gray coded along fetch, check, move, write back
  typedef enum logic [2:0] {
    DSQ_IDLE  = 3'h0,
    DSQ_FETCH = 3'h1,
    DSQ_CHECK = 3'h3,
    DSQ_MOVE  = 3'h2,
    DSQ_WB    = 3'h6,
    DSQ_CP_RD = 3'h7,
    DSQ_CP_WR = 3'h5
  } dsq_state_t;

  // one control table access
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dsq_mem_cmd_t;

  // state of the memory port
  typedef struct packed {
    logic         req;
    dsq_mem_cmd_t cmd;
    logic         done;
    logic [31:0]  rdata;
  } dsq_mem_t;

  // state of the request picker
  typedef struct packed {
    logic       valid;
    logic [4:0] ch;
  } dsq_pick_t;

  // state of the sequencer
  typedef struct packed {
    dsq_state_t   st;
    logic [4:0]   ch;
    logic         phase;
    logic         pend;
    logic         cp;
    logic         sgp;
    logic [1:0]   w;
    logic [31:0]  src;
    logic [31:0]  dst;
    logic [31:0]  cw;
    logic [31:0]  cpy;
    logic [31:0]  alt;
    logic [31:0]  clr;
    logic [31:0]  irq;
    logic         go;
    logic         cmd_v;
    dsq_mem_cmd_t cmd;
  } dsq_seq_t;

endpackage : dsq_pkg

// File: src/dsq_pick.sv
// request picker: lowest numbered enabled channel with a pending request
`timescale 1ns/1ns
`include "dsq_map.svh"

module dsq_pick (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [31:0]       req,
  input  wire logic [31:0]       en,
  output dsq_pkg::dsq_pick_t     pick
);

  dsq_pkg::dsq_pick_t s;       // registered choice
  dsq_pkg::dsq_pick_t next_s;  // next choice

  ////////////////////////////////////////////////////////////////////////
  // fixed priority: channel 0 wins; software trigger writes arrive here
  // as ordinary requests, so a list can launch other channels
  always_comb begin
    next_s = '0;
    for (int i = `DSQ_NCH - 1; i >= 0; i--) begin
      if (req[i] && en[i]) begin
        next_s.valid = 1'b1;
        next_s.ch    = 5'(i);
      end
    end
  end

  // register the choice
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pick = s;

endmodule : dsq_pick

// File: src/dsq_mem.sv
// control table port: holds a request until the memory acknowledges it
`timescale 1ns/1ns

module dsq_mem (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  cmd_v,
  input  dsq_pkg::dsq_mem_cmd_t      cmd,
  input  wire logic                  mem_ack,
  input  wire logic [31:0]           mem_rdata,
  output logic                       mem_req,
  output dsq_pkg::dsq_mem_cmd_t      mem_cmd,
  output logic                       done,
  output logic [31:0]                rdata
);

  dsq_pkg::dsq_mem_t s;       // port state
  dsq_pkg::dsq_mem_t next_s;  // next port state

  ////////////////////////////////////////////////////////////////////////
  // one access at a time; the sequencer waits for done before the next
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (cmd_v) begin
      next_s.req = 1'b1;
      next_s.cmd = cmd;
    end else if (s.req && mem_ack) begin
      next_s.req   = 1'b0;
      next_s.done  = 1'b1;
      next_s.rdata = mem_rdata;
    end
  end

  // register the port
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mem_req = s.req;
  assign mem_cmd = s.cmd;
  assign done    = s.done;
  assign rdata   = s.rdata;

endmodule : dsq_mem

// File: src/dsq_seq.sv
// dma transfer mode sequencer: stop, basic, auto, ping-pong, scatter-gather
`timescale 1ns/1ns
`include "dsq_map.svh"

module dsq_seq (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [31:0]        ch_en,
  input  wire logic [31:0]        dma_req,
  input  wire logic [31:0]        ctl_base,
  input  wire logic               item_done,
  input  wire logic               mem_ack,
  input  wire logic [31:0]        mem_rdata,
  output logic                    item_go,
  output logic [4:0]              item_ch,
  output logic [31:0]             item_src_end,
  output logic [31:0]             item_dst_end,
  output logic [9:0]              item_left,
  output logic                    mem_req,
  output logic                    mem_we,
  output logic [31:0]             mem_addr,
  output logic [31:0]             mem_wdata,
  output logic [31:0]             ch_clr,
  output logic [31:0]             done_irq,
  output logic [31:0]             alt_active
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  dsq_pkg::dsq_seq_t     s;        // sequencer state
  dsq_pkg::dsq_seq_t     next_s;   // next sequencer state
  dsq_pkg::dsq_pick_t    pick;     // chosen requester
  dsq_pkg::dsq_mem_cmd_t mcmd;     // access on the memory pins
  logic                  m_done;   // access finished, one cycle
  logic [31:0]           m_rdata;  // data of a finished read
  logic [2:0]            mode;     // mode field of the held word
  logic [9:0]            cnt;      // item count of the held word

  assign mode = s.cw[`DSQ_MODE_LSB +: `DSQ_MODE_W];
  assign cnt  = s.cw[`DSQ_CNT_LSB +: `DSQ_CNT_W];

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // modes that move only while the requester asserts its request
  function automatic logic gated(input logic [2:0] m, input logic ph);
    gated = (m == `DSQ_M_BASIC && !ph) || m == `DSQ_M_PP;
  endfunction : gated

  // both scatter-gather flavours
  function automatic logic is_sg(input logic [2:0] m);
    is_sg = (m == `DSQ_M_MSG) || (m == `DSQ_M_PSG);
  endfunction : is_sg

  // byte address of one word of a control structure
  function automatic logic [31:0] taddr(input logic [31:0] base,
                                        input logic ph,
                                        input logic [4:0] ch,
                                        input logic [1:0] w);
    taddr = {base[31:`DSQ_BASE_LSB], 10'h000}
          + (ph ? `DSQ_ALT_OFF : 32'h0000_0000)
          + ({27'h0, ch} << `DSQ_STRIDE_SH)
          + {28'h0, w, 2'h0};
  endfunction : taddr

  ////////////////////////////////////////////////////////////////////////
  // helpers

  dsq_pick u_pick (
    .clk  (clk),
    .rst  (rst),
    .req  (dma_req),
    .en   (ch_en),
    .pick (pick)
  );

  dsq_mem u_mem (
    .clk       (clk),
    .rst       (rst),
    .cmd_v     (s.cmd_v),
    .cmd       (s.cmd),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata),
    .mem_req   (mem_req),
    .mem_cmd   (mcmd),
    .done      (m_done),
    .rdata     (m_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  // every table access is issued once (pend set) and then waited for;
  // the control word is re-read from memory on every start so that a
  // list entry that rewrote the primary structure takes effect
  always_comb begin
    next_s       = s;
    next_s.clr   = '0;
    next_s.irq   = '0;
    next_s.cmd_v = 1'b0;
    unique case (s.st)
      // wait for a live, enabled request
      dsq_pkg::DSQ_IDLE: begin
        // recheck the live request: the pick is one cycle old; a channel
        // cleared last cycle is skipped, its outside enable drops a cycle late
        if (pick.valid && dma_req[pick.ch] && ch_en[pick.ch]
            && !s.clr[pick.ch]) begin
          next_s.ch    = pick.ch;
          next_s.phase = s.alt[pick.ch];
          next_s.w     = `DSQ_W_SRC;
          next_s.cp    = 1'b0;
          next_s.st    = dsq_pkg::DSQ_FETCH;
        end
      end
      // read source end, destination end and control word
      dsq_pkg::DSQ_FETCH: begin
        if (!s.pend) begin
          next_s.pend      = 1'b1;
          next_s.cmd_v     = 1'b1;
          next_s.cmd.we    = 1'b0;
          next_s.cmd.addr  = taddr(ctl_base, s.phase, s.ch, s.w);
          next_s.cmd.wdata = '0;
        end else if (m_done) begin
          next_s.pend = 1'b0;
          unique case (s.w)
            `DSQ_W_SRC: next_s.src = m_rdata;
            `DSQ_W_DST: next_s.dst = m_rdata;
            default:    next_s.cw  = m_rdata;
          endcase
          if (s.w == `DSQ_W_CW) begin
            next_s.st = dsq_pkg::DSQ_CHECK;
          end else begin
            next_s.w = s.w + 2'h1;
          end
        end
      end
      // pick the action from the mode field
      dsq_pkg::DSQ_CHECK: begin
        if (mode == `DSQ_M_STOP) begin
          // no transfer; drop the enable
          next_s.clr[s.ch] = 1'b1;
          next_s.st        = dsq_pkg::DSQ_IDLE;
        end else if (!s.phase && is_sg(mode) && cnt != 10'h000) begin
          // primary is a copy job feeding the alternate
          next_s.sgp = (mode == `DSQ_M_PSG);
          next_s.w   = `DSQ_W_SRC;
          next_s.st  = dsq_pkg::DSQ_CP_RD;
        end else if (cnt == 10'h000) begin
          // nothing left: finish without a move
          next_s.st = dsq_pkg::DSQ_WB;
        end else if (gated(mode, s.phase) && !dma_req[s.ch]) begin
          next_s.st = dsq_pkg::DSQ_WB;
        end else begin
          next_s.go = 1'b1;
          next_s.st = dsq_pkg::DSQ_MOVE;
        end
      end
      // one item per go/done handshake; go drops a cycle between items
      // so the mover always sees the updated count
      dsq_pkg::DSQ_MOVE: begin
        if (s.go) begin
          if (item_done) begin
            next_s.go = 1'b0;
            next_s.cw[`DSQ_CNT_LSB +: `DSQ_CNT_W] = cnt - 10'h001;
            if (cnt == 10'h001) begin
              next_s.st = dsq_pkg::DSQ_WB;
            end
          end
        end else if (gated(mode, s.phase) && !dma_req[s.ch]) begin
          // request gone: a momentary request moved just one item
          next_s.st = dsq_pkg::DSQ_WB;
        end else begin
          // auto and list entries ignore a withdrawn request
          next_s.go = 1'b1;
        end
      end
      // write the control word back, then decide what follows
      dsq_pkg::DSQ_WB: begin
        if (!s.pend) begin
          next_s.pend      = 1'b1;
          next_s.cmd_v     = 1'b1;
          next_s.cmd.we    = 1'b1;
          next_s.cmd.addr  = taddr(ctl_base, s.phase, s.ch, `DSQ_W_CW);
          next_s.cmd.wdata = s.cw;
          if (cnt == 10'h000) begin
            next_s.cmd.wdata[`DSQ_MODE_LSB +: `DSQ_MODE_W] = `DSQ_M_STOP;
          end
        end else if (m_done) begin
          next_s.pend = 1'b0;
          next_s.st   = dsq_pkg::DSQ_IDLE;
          if (s.cp) begin
            // entry copied: execute it from the alternate
            next_s.cp    = 1'b0;
            next_s.phase = 1'b1;
            next_s.w     = `DSQ_W_SRC;
            next_s.st    = dsq_pkg::DSQ_FETCH;
          end else if (cnt != 10'h000) begin
            // paused basic or ping-pong transfer, resumes on a later request
            next_s.st = dsq_pkg::DSQ_IDLE;
          end else if (mode == `DSQ_M_PP) begin
            // hand over to the other structure, enable stays set
            next_s.irq[s.ch] = 1'b1;
            next_s.alt[s.ch] = ~s.alt[s.ch];
          end else if (s.phase && is_sg(mode)) begin
            // intermediate entry: no interrupt
            if (!s.sgp) begin
              next_s.phase = 1'b0;
              next_s.w     = `DSQ_W_SRC;
              next_s.st    = dsq_pkg::DSQ_FETCH;
            end
            // peripheral list: wait in idle for the next request
          end else begin
            // basic, auto, last list entry or exhausted list
            next_s.irq[s.ch] = 1'b1;
            next_s.clr[s.ch] = 1'b1;
          end
        end
      end
      // read one task list word; the list is walked up to its end pointer
      dsq_pkg::DSQ_CP_RD: begin
        if (!s.pend) begin
          next_s.pend      = 1'b1;
          next_s.cmd_v     = 1'b1;
          next_s.cmd.we    = 1'b0;
          next_s.cmd.addr  = s.src - {20'h0, cnt - 10'h001, 2'h0};
          next_s.cmd.wdata = '0;
        end else if (m_done) begin
          next_s.pend = 1'b0;
          next_s.cpy  = m_rdata;
          next_s.st   = dsq_pkg::DSQ_CP_WR;
        end
      end
      // place that word in the alternate structure
      dsq_pkg::DSQ_CP_WR: begin
        if (!s.pend) begin
          next_s.pend      = 1'b1;
          next_s.cmd_v     = 1'b1;
          next_s.cmd.we    = 1'b1;
          next_s.cmd.addr  = taddr(ctl_base, 1'b1, s.ch, s.w);
          next_s.cmd.wdata = s.cpy;
        end else if (m_done) begin
          next_s.pend = 1'b0;
          next_s.cw[`DSQ_CNT_LSB +: `DSQ_CNT_W] = cnt - 10'h001;
          if (s.w == `DSQ_W_LAST) begin
            // whole entry copied: store the primary count
            next_s.cp = 1'b1;
            next_s.st = dsq_pkg::DSQ_WB;
          end else begin
            next_s.w  = s.w + 2'h1;
            next_s.st = dsq_pkg::DSQ_CP_RD;
          end
        end
      end
      default: begin
        // 3'h4 is unused; recover to idle
        next_s.st   = dsq_pkg::DSQ_IDLE;
        next_s.pend = 1'b0;
        next_s.go   = 1'b0;
      end
    endcase
  end

  // register the state; alternate flags start on the primary
  always_ff @(posedge clk) begin
    if (rst) begin
      s     <= '0;
      s.alt <= `DSQ_RST_ALT;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign item_go      = s.go;
  assign item_ch      = s.ch;
  assign item_src_end = s.src;
  assign item_dst_end = s.dst;
  assign item_left    = cnt;
  assign mem_we       = mcmd.we;
  assign mem_addr     = mcmd.addr;
  assign mem_wdata    = mcmd.wdata;
  assign ch_clr       = s.clr;
  assign done_irq     = s.irq;
  assign alt_active   = s.alt;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // write back of a finished word completing, not after a copy
  sequence sq_wb_end;
    s.st == dsq_pkg::DSQ_WB && s.pend && m_done && !s.cp && cnt == 10'h000;
  endsequence

  // item of a gated transfer, not the last, with the request low a cycle later
  sequence sq_gated_drop;
    s.st == dsq_pkg::DSQ_MOVE && s.go && item_done && cnt > 10'h001
      && gated(mode, s.phase) ##1 !dma_req[s.ch];
  endsequence

  chk_stop_disables: assert property (
    s.st == dsq_pkg::DSQ_CHECK && mode == `DSQ_M_STOP
      |=> ch_clr != 32'h0 && !item_go && s.st == dsq_pkg::DSQ_IDLE)
    else $error("stop mode did not disable the channel");

  chk_stop_written: assert property (
    s.st == dsq_pkg::DSQ_WB && !s.pend && cnt == 10'h000
      |-> ##2 mem_req && mem_we
        && mem_wdata[`DSQ_MODE_LSB +: `DSQ_MODE_W] == `DSQ_M_STOP
        && mem_wdata[`DSQ_CNT_LSB +: `DSQ_CNT_W] == 10'h000)
    else $error("finished word not written back as stop");

  chk_basic_gate: assert property (
    $rose(item_go) && gated(mode, s.phase) |-> $past(dma_req[s.ch]))
    else $error("gated item started without a request");

  chk_momentary_one: assert property (
    sq_gated_drop |=> s.st == dsq_pkg::DSQ_WB && !item_go)
    else $error("item moved after the request was withdrawn");

  chk_auto_runs: assert property (
    s.st == dsq_pkg::DSQ_MOVE && mode == `DSQ_M_AUTO && s.go && item_done
      && cnt > 10'h001 |=> !item_go ##1 item_go)
    else $error("auto transfer stalled before completion");

  chk_pp_handover: assert property (
    sq_wb_end and (mode == `DSQ_M_PP)
      |=> done_irq != 32'h0 && ch_clr == 32'h0
        && alt_active != $past(alt_active))
    else $error("ping-pong hand-over missed interrupt or toggle");

  chk_sg_quiet: assert property (
    sq_wb_end and (s.phase && is_sg(mode))
      |=> done_irq == 32'h0 ##1 done_irq == 32'h0)
    else $error("interrupt raised after an intermediate entry");

  chk_msg_refetch: assert property (
    sq_wb_end and (s.phase && is_sg(mode) && !s.sgp)
      |=> s.st == dsq_pkg::DSQ_FETCH && !s.phase)
    else $error("memory list did not continue with the primary");

  chk_psg_waits: assert property (
    sq_wb_end and (s.phase && is_sg(mode) && s.sgp)
      |=> s.st == dsq_pkg::DSQ_IDLE)
    else $error("peripheral list continued without a request");

  chk_copy_alt: assert property (
    s.st == dsq_pkg::DSQ_CP_WR && !s.pend
      |-> ##2 mem_req && mem_we && (mem_addr & `DSQ_ALT_OFF) != 32'h0)
    else $error("list entry not written to the alternate structure");

  chk_final_clear: assert property (
    done_irq != 32'h0 && ch_clr != 32'h0 |-> done_irq == ch_clr)
    else $error("completion cleared the wrong channel");

endmodule : dsq_seq

// File: verification/dsq_far_model.sv
// far side model: control table memory and item mover
`timescale 1ns/1ns

module dsq_far_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        item_go,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic             item_done
);
  logic [31:0] m [int];             // sparse table memory
  int          seed = 32'h2ca637e2; // fixed seed for wait lengths
  int          mw = 0;              // memory wait cycles left
  int          gw = 0;              // mover wait cycles left

  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 32'h0;
    item_done = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // memory answers after 0 to 2 cycles; idle data toggles so a
  // stale word is never mistaken for a fresh read
  always @(posedge clk) begin
    #1;
    if (mem_ack) begin
      mem_ack   = 1'b0;
      mem_rdata = ~mem_rdata;
    end else if (mem_req && mw > 0) begin
      mw = mw - 1;
    end else if (mem_req) begin
      mem_ack   = 1'b1;
      mem_rdata = m.exists(mem_addr) ? m[mem_addr] : 32'h0;
      if (mem_we) m[mem_addr] = mem_wdata;
      mw = $unsigned($random(seed)) % 3;
    end else begin
      mem_rdata = ~mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // mover finishes each item after 0 to 2 cycles
  always @(posedge clk) begin
    #1;
    if (item_done) begin
      item_done = 1'b0;
    end else if (item_go && gw > 0) begin
      gw = gw - 1;
    end else if (item_go) begin
      item_done = 1'b1;
      gw = $unsigned($random(seed)) % 3;
    end
  end
endmodule : dsq_far_model

// File: verification/dma_transfer_mode_sequencer_test.sv
// self-checking bench of the dma transfer mode sequencer
`timescale 1ns/1ns
`include "dsq_map.svh"

module dma_transfer_mode_sequencer_test;
  localparam logic [31:0] BASE = 32'h0000_1000; // table base, 1 KiB aligned
  logic        clk, rst, item_go, item_done, mem_req, mem_we, mem_ack;
  logic [31:0] ch_en, dma_req, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] ch_clr, done_irq, alt_active, src_end, last_src, dst_end, last_dst;
  logic [31:0] exp_src [$]; // source end pointer expected per item
  logic [31:0] s, sa, da, sb, db; // random pointers
  logic [4:0]  item_ch;
  logic [9:0]  item_left;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          seed = 32'h2ca637e2;
  int          items [32] = '{default: 0}; // items moved per channel
  int          irqs [32] = '{default: 0};  // completion pulses per channel
  int          clrs [32] = '{default: 0};  // enable clear pulses per channel

  dsq_seq dut (
    .clk(clk), .rst(rst), .ch_en(ch_en), .dma_req(dma_req), .ctl_base(BASE),
    .item_done(item_done), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .item_go(item_go), .item_ch(item_ch), .item_src_end(src_end),
    .item_dst_end(dst_end), .item_left(item_left), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .ch_clr(ch_clr), .done_irq(done_irq), .alt_active(alt_active));

  dsq_far_model far (
    .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .item_go(item_go), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .item_done(item_done));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  // monitor; the external enable register obeys the clear pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
    for (int i = 0; i < 32; i++) begin
      if (ch_clr[i] === 1'b1) clrs[i]++;
      if (done_irq[i] === 1'b1) irqs[i]++;
    end
    if (item_go === 1'b1 && item_done === 1'b1) begin
      items[item_ch]++;
      last_src <= src_end;
      last_dst <= dst_end;
      if (exp_src.size() == 0) exp_src.push_back(~src_end);
      chk(src_end, exp_src.pop_front());
    end
    if (!rst) ch_en <= ch_en & ~ch_clr;
  end

  // byte address of one structure word
  function automatic logic [31:0] ad(int c, int alt, int w);
    return BASE + alt * `DSQ_ALT_OFF + c * 16 + w * 4;
  endfunction : ad

  // control word: mode in the low bits, remaining count above
  function automatic logic [31:0] cw(logic [2:0] md, int n);
    return {18'h0, n[9:0], 1'b0, md};
  endfunction : cw

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic put(logic [31:0] a, logic [31:0] p, logic [31:0] q, logic [31:0] w);
    far.m[a] = p;
    far.m[a + 4] = q;
    far.m[a + 8] = w;
  endtask : put

  // two entry list; only the last entry is basic
  task automatic lst(int c, logic [31:0] lb, logic [2:0] md);
    put(lb, sa, da, cw(md, 2));
    put(lb + 16, sb, db, cw(`DSQ_M_BASIC, 1));
    put(ad(c, 0, 0), lb + 28, 32'h0, cw(md, 8));
  endtask : lst

  // queue the source end pointer expected for the next n items
  task automatic want(logic [31:0] v, int n);
    repeat (n) exp_src.push_back(v);
  endtask : want

  // momentary request: dropped as soon as the first item moves
  task automatic kick(int c);
    int k;
    ch_en[c] = 1'b1;
    dma_req[c] = 1'b1;
    for (k = 0; k < 300 && !(item_go === 1'b1 && item_ch == c) && ch_clr[c] !== 1'b1; k++)
      @(posedge clk);
    #1 dma_req[c] = 1'b0;
  endtask : kick

  // wait, bounded, until the ports stay quiet
  task automatic settle();
    int q = 0;
    for (int k = 0; k < 2000 && q < 12; k++) begin
      @(posedge clk);
      q = (mem_req || item_go) ? 0 : q + 1;
    end
    #1;
  endtask : settle

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////
  initial begin
    int k;
    rst = 1'b1;
    ch_en = 32'h0;
    dma_req = 32'h0;
    s = $random(seed);
    sa = $random(seed);
    da = $random(seed);
    sb = $random(seed);
    db = $random(seed);
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    // stop mode only clears the enable
    put(ad(1, 0, 0), s, s, cw(`DSQ_M_STOP, 3));
    kick(1);
    settle();
    chk(clrs[1], 1);
    chk(items[1] + irqs[1], 0);
    $display("stop test done");
    // auto runs on after the request is gone
    put(ad(2, 0, 0), s, ~s, cw(`DSQ_M_AUTO, 4));
    want(s, 4);
    kick(2);
    settle();
    chk(items[2], 4);
    chk(far.m[ad(2, 0, 2)], cw(`DSQ_M_STOP, 0));
    chk(item_left, 0);
    chk(irqs[2], 1);
    chk(clrs[2], 1);
    chk(last_src, s);
    chk(last_dst, ~s);
    $display("auto test done");
    // basic: one item per momentary request, then held request
    put(ad(3, 0, 0), s, s, cw(`DSQ_M_BASIC, 3));
    want(s, 3);
    kick(3);
    settle();
    chk(items[3], 1);
    chk(far.m[ad(3, 0, 2)], cw(`DSQ_M_BASIC, 2));
    chk(item_left, 2);
    chk(irqs[3] + clrs[3], 0);
    dma_req[3] = 1'b1;
    settle();
    dma_req[3] = 1'b0;
    chk(items[3], 3);
    chk(far.m[ad(3, 0, 2)], cw(`DSQ_M_STOP, 0));
    chk(irqs[3], 1);
    $display("basic test done");
    // ping-pong, primary refreshed after the first hand-over
    put(ad(4, 0, 0), s, s, cw(`DSQ_M_PP, 2));
    put(ad(4, 1, 0), ~s, s, cw(`DSQ_M_PP, 1));
    want(s, 2);
    want(~s, 1);
    want(sa, 1);
    ch_en[4] = 1'b1;
    dma_req[4] = 1'b1;
    for (k = 0; k < 500 && irqs[4] < 1; k++) @(posedge clk);
    @(posedge clk);
    #1 chk(alt_active[4], 1);
    chk(items[4], 2);
    put(ad(4, 0, 0), sa, s, cw(`DSQ_M_PP, 1));
    settle();
    dma_req[4] = 1'b0;
    chk(items[4], 4);
    chk(irqs[4], 3);
    chk(clrs[4], 1);
    $display("ping-pong test done");
    // memory list: one request runs both entries
    lst(5, 32'h0000_4000, `DSQ_M_MSG);
    want(sa, 2);
    want(sb, 1);
    kick(5);
    settle();
    chk(items[5], 3);
    chk(irqs[5], 1);
    chk(last_src, sb);
    chk(last_dst, db);
    chk(far.m[ad(5, 1, 1)], db);
    chk(far.m[ad(5, 1, 2)], cw(`DSQ_M_STOP, 0));
    // primary rewritten to the list start: the list runs again
    lst(5, 32'h0000_4000, `DSQ_M_MSG);
    want(sa, 2);
    want(sb, 1);
    kick(5);
    settle();
    chk(items[5], 6);
    chk(irqs[5], 2);
    $display("memory list test done");
    // peripheral list: one entry per request
    lst(6, 32'h0000_5000, `DSQ_M_PSG);
    want(sa, 2);
    want(sb, 1);
    kick(6);
    settle();
    chk(items[6], 2);
    chk(irqs[6], 0);
    kick(6);
    settle();
    chk(items[6], 3);
    chk(irqs[6], 1);
    chk(exp_src.size(), 0);
    $display("peripheral list test done");
    results();
  end
endmodule : dma_transfer_mode_sequencer_test
